// file: src/tcw_pkg.sv
// Constants, types and register map of the timer compare and waveform unit.
// Assumes an APB master on pclk; every register is one aligned 32-bit word.
// Contract
// [R1] Channel flag set one tick after equality
// [R2] Valid compare buffer copied on update
// [R3] Output needs mode, no event counting, enable
// [R4] Enabled waveform replaces pin value, optionally inverted
// [R5] Frequency mode: channel zero sets period, toggles
// [R6] Frequency output is clock over 2N(compare+1)
// [R7] Single slope: set at bottom, clear on match
// [R8] Single slope: zero low, above top high
// [R9] Software keeps single-slope period in range
// [R10] Dual slope: up clears, down sets output
// [R11] Dual slope: zero low, equal top high
// [R12] Software keeps dual-slope period in range
// [R13] Command field write acts at once
// [R14] Update command ignores lock bit
// [R15] Restart clears counter, direction, outputs
// [R16] Reset command only while timer disabled
// [R17] Split mode: two 8-bit down-counters
// [R18] Split: high underflow flag, no high compare
// [R19] Split: buffers unused, byte access everywhere
// [R20] Software resets before changing mode
// [R21] Software sets split, period, then enable
// [R22] Update at top or bottom unless locked
// [R23] Bottom is zero, max is all ones
// [R24] Split counters use own compare bytes
// [R25] Prescaler select picks divider for ticks
package tcw_pkg;

  localparam int unsigned CNT_W = 16;
  localparam int unsigned NCH = 3;
  localparam int unsigned NWO = 6;
  localparam int unsigned PSC_W = 10;

  typedef logic [CNT_W-1:0] tcw_word_t;

  typedef enum logic [2:0] {
    WG_NORMAL = 3'h0,
    WG_FREQ = 3'h1,
    WG_SINGLE = 3'h3,
    WG_DUAL = 3'h5
  } tcw_waveform_mode_select_e;

  typedef enum logic [1:0] {
    CMD_NONE = 2'h0,
    CMD_UPDATE = 2'h1,
    CMD_RESTART = 2'h2,
    CMD_RESET = 2'h3
  } tcw_cmd_e;

  // Register byte offsets
  localparam logic [7:0] OFS_CTRL_A = 8'h00;
  localparam logic [7:0] OFS_CTRL_B = 8'h04;
  localparam logic [7:0] OFS_CONTROL_D = 8'h08;
  localparam logic [7:0] OFS_CTRL_E_CLR = 8'h0c;
  localparam logic [7:0] OFS_CONTROL_E_SET = 8'h10;
  localparam logic [7:0] OFS_BUF_VALID = 8'h14;
  localparam logic [7:0] OFS_EVENT_CTRL = 8'h18;
  localparam logic [7:0] OFS_FLAGS = 8'h1c;
  localparam logic [7:0] OFS_COUNT = 8'h20;
  localparam logic [7:0] OFS_PERIOD = 8'h24;
  localparam logic [7:0] OFS_PERIOD_BUF = 8'h28;
  localparam logic [7:0] OFS_COMPARE0 = 8'h2c;
  localparam logic [7:0] OFS_COMPBUF0 = 8'h38;

  // Field positions
  localparam int unsigned ENABLE_BIT = 0;
  localparam int unsigned PSEL_LSB = 1;
  localparam int unsigned WAVEFORM_MODE_SELECT_LSB = 0;
  localparam int unsigned CHEN_LSB = 4;
  localparam int unsigned DIR_BIT = 0;
  localparam int unsigned LOCK_BIT = 1;
  localparam int unsigned CMD_LSB = 2;
  localparam int unsigned FLG_OVF = 0;
  localparam int unsigned FLG_HUNF = 1;
  localparam int unsigned FLG_CMP_LSB = 4;

  // Control bits grouped as one register set
  typedef struct packed {
    logic enable;
    logic [2:0] prescaler_select;
    logic [2:0] waveform_mode_select;
    logic [NCH-1:0] channel_output_enable;
    logic split_mode_bit;
    logic dir_down;
    logic lock_update_bit;
    logic count_on_event_enable;
  } tcw_ctrl_s;

  // Values after reset
  localparam tcw_ctrl_s CTRL_RST = '0;
  localparam tcw_word_t COUNT_RST = 16'h0000;
  localparam tcw_word_t PERIOD_RST = 16'hffff;
  localparam tcw_word_t COMPARE_RST = 16'h0000;
  localparam logic [7:0] FLAGS_RST = 8'h00;
  localparam logic [3:0] BV_RST = 4'h0;

endpackage : tcw_pkg

// file: src/tcw_prescaler.sv
// Prescaler that turns pclk into count ticks for the timer.
// Assumes run drops whenever the timer is disabled or restarted.
`timescale 1ns/10ps
module tcw_prescaler import tcw_pkg::*; (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Control
  input wire logic run,
  input wire logic [2:0] prescaler_select,
  // Tick out
  output logic tick
);

  logic [PSC_W-1:0] psc_q;
  logic [PSC_W-1:0] psc_d;
  logic [PSC_W-1:0] mask;

  // Divider N: 1, 2, 4, 8, 16, 64, 256, 1024
  function automatic logic [PSC_W-1:0] div_mask(logic [2:0] sel);
    case (sel)
      3'h0: div_mask = 10'h000;
      3'h1: div_mask = 10'h001;
      3'h2: div_mask = 10'h003;
      3'h3: div_mask = 10'h007;
      3'h4: div_mask = 10'h00f;
      3'h5: div_mask = 10'h03f;
      3'h6: div_mask = 10'h0ff;
      default: div_mask = 10'h3ff;
    endcase
  endfunction : div_mask

  // Tick when the low bits are all ones; free count restarts when stopped
  always_comb begin
    mask = div_mask(prescaler_select); // [R25]
    tick = run && ((psc_q & mask) == mask);
    psc_d = run ? psc_q + 10'h001 : 10'h000;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      psc_q <= 10'h000;
    end else begin
      psc_q <= psc_d;
    end
  end

endmodule : tcw_prescaler

// file: src/tcw_wavegen.sv
// One waveform generator channel: frequency, single- and dual-slope PWM.
// Assumes next_value is the counter value that the current tick produces.
`timescale 1ns/10ps
module tcw_wavegen import tcw_pkg::*; (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Timer state
  input wire logic [2:0] waveform_mode_select,
  input wire logic adv,
  input wire logic clear,
  input wire logic match,
  input wire tcw_word_t next_value,
  input wire tcw_word_t compare_value,
  input wire logic compare_at_top,
  // Waveform
  output logic waveform_output
);

  logic wo_q;
  logic wo_d;

  // Level PWM from the next count keeps the edges glitch-free and makes
  // the static cases fall out of the comparison itself, all but dual-slope compare at top
  always_comb begin
    wo_d = wo_q;
    if (clear) begin
      wo_d = 1'b0; // [R15]
    end else if (adv) begin
      case (waveform_mode_select)
        WG_FREQ: wo_d = wo_q ^ match; // [R5]
        WG_SINGLE: wo_d = next_value < compare_value; // [R7] [R8]
        WG_DUAL: wo_d = (next_value < compare_value) || compare_at_top; // [R10] [R11]
        default: wo_d = wo_q;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wo_q <= 1'b0;
    end else begin
      wo_q <= wo_d;
    end
  end

  assign waveform_output = wo_q;

endmodule : tcw_wavegen

// file: src/tcw_top.sv
// Timer compare and waveform unit with an APB register slave.
// Assumes a synchronous port_out_value and count_event on pclk, zero-wait APB.
`timescale 1ns/10ps
module tcw_top import tcw_pkg::*; (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic [7:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Count source
  input wire logic count_event,
  // Port pins
  input wire logic [NWO-1:0] port_out_value,
  input wire logic [NWO-1:0] pin_invert_enable,
  output logic [NWO-1:0] pin_value,
  output logic [NWO-1:0] waveform_output
);

  tcw_ctrl_s ctrl_q, ctrl_d;
  tcw_word_t count_q, count_d, count_nat, period_q, period_d, perbuf_q, perbuf_d, top;
  tcw_word_t [NCH-1:0] compare_value_q, compare_value_d, compare_buffer_q, compare_buffer_d;
  logic [3:0] bv_q, bv_d;
  logic [7:0] flags_q, flags_d, flag_set, flag_clr;
  logic [31:0] prdata_q, prdata_d;
  logic pslverr_q, pslverr_d;
  logic [NWO-1:0] pin_q, pin_d, ovr;
  logic tick, adv, dir_nat, ovf_evt, hunf_evt, upd, wr_acc, rd_setup, wave_ok;
  logic [NCH-1:0] eq;
  logic [1:0] cmd;
  logic [2:0] wg_mode [NWO];
  tcw_word_t wg_next [NWO];
  tcw_word_t wg_cmp [NWO];
  logic [NWO-1:0] wg_match, wg_top;

  // Byte lanes let split mode reach each counter byte on its own
  function automatic tcw_word_t merge(tcw_word_t old, logic [31:0] wd, logic [3:0] st);
    merge = {st[1] ? wd[15:8] : old[15:8], st[0] ? wd[7:0] : old[7:0]}; // [R19]
  endfunction : merge

  function automatic logic mapped(logic [7:0] a);
    mapped = (a[1:0] == 2'b00) && (a <= OFS_COMPBUF0 + 8'h08);
  endfunction : mapped

  // Prescaler runs only while enabled and not restarted
  tcw_prescaler u_psc (
    .pclk(pclk),
    .presetn(presetn),
    .run(ctrl_q.enable && (cmd != CMD_RESTART)),
    .prescaler_select(ctrl_q.prescaler_select),
    .tick(tick)
  );

  // Bus phases and commands
  always_comb begin
    wr_acc = psel && penable && pwrite;
    rd_setup = psel && !penable;
    cmd = CMD_NONE;
    if (wr_acc && paddr == OFS_CONTROL_E_SET && pstrb[0]) begin
      cmd = pwdata[CMD_LSB +: 2]; // [R13]
    end
  end

  // Counting, top selection and timer events
  always_comb begin
    top = (ctrl_q.waveform_mode_select == WG_FREQ) ? compare_value_q[0] : period_q; // [R5] [R6]
    // Events are ignored in split mode
    adv = ctrl_q.enable && ((ctrl_q.count_on_event_enable && !ctrl_q.split_mode_bit)
          ? count_event : tick); // [R25]
    count_nat = count_q;
    dir_nat = ctrl_q.dir_down;
    ovf_evt = 1'b0;
    hunf_evt = 1'b0;
    if (adv) begin
      if (ctrl_q.split_mode_bit) begin
        // Two independent byte down-counters
        ovf_evt = (count_q[7:0] == 8'h00); // [R17] [R18]
        hunf_evt = (count_q[15:8] == 8'h00); // [R18]
        count_nat[7:0] = ovf_evt ? period_q[7:0] : count_q[7:0] - 8'h01; // [R17]
        count_nat[15:8] = hunf_evt ? period_q[15:8] : count_q[15:8] - 8'h01; // [R17]
      end else if (ctrl_q.waveform_mode_select == WG_DUAL) begin
        if (!ctrl_q.dir_down) begin
          ovf_evt = (count_q >= top);
          dir_nat = ovf_evt; // [R10]
          count_nat = ovf_evt ? count_q - 16'h0001 : count_q + 16'h0001;
        end else begin
          ovf_evt = (count_q == 16'h0000); // [R23]
          dir_nat = !ovf_evt; // [R10]
          count_nat = ovf_evt ? count_q + 16'h0001 : count_q - 16'h0001;
        end
      end else if (!ctrl_q.dir_down) begin
        ovf_evt = (count_q >= top);
        count_nat = ovf_evt ? 16'h0000 : count_q + 16'h0001; // [R7] [R23]
      end else begin
        ovf_evt = (count_q == 16'h0000); // [R23]
        count_nat = ovf_evt ? top : count_q - 16'h0001;
      end
    end
    for (int i = 0; i < NCH; i++) begin
      eq[i] = ctrl_q.split_mode_bit ? (count_q[7:0] == compare_value_q[i][7:0])
              : (count_q == compare_value_q[i]); // [R1] [R24]
    end
    // Dual slope updates at bottom, the others when the cycle wraps
    upd = !ctrl_q.split_mode_bit && ((ovf_evt && !ctrl_q.lock_update_bit
          && !(ctrl_q.waveform_mode_select == WG_DUAL && !ctrl_q.dir_down))
          || cmd == CMD_UPDATE); // [R14] [R19] [R22]
  end

  // Register file next state: hardware first, then bus writes, then commands
  always_comb begin
    ctrl_d = ctrl_q;
    count_d = count_nat;
    period_d = period_q;
    perbuf_d = perbuf_q;
    compare_value_d = compare_value_q;
    compare_buffer_d = compare_buffer_q;
    bv_d = bv_q;
    ctrl_d.dir_down = dir_nat;
    if (upd) begin
      if (bv_q[0]) begin
        period_d = perbuf_q; // [R22]
      end
      for (int i = 0; i < NCH; i++) begin
        if (bv_q[i+1]) begin
          compare_value_d[i] = compare_buffer_q[i]; // [R2]
        end
      end
      bv_d = 4'h0;
    end
    if (wr_acc) begin
      case (paddr)
        OFS_CTRL_A: if (pstrb[0]) begin
          ctrl_d.enable = pwdata[ENABLE_BIT];
          ctrl_d.prescaler_select = pwdata[PSEL_LSB +: 3];
        end
        OFS_CTRL_B: if (pstrb[0]) begin
          ctrl_d.waveform_mode_select = pwdata[WAVEFORM_MODE_SELECT_LSB +: 3];
          ctrl_d.channel_output_enable = pwdata[CHEN_LSB +: NCH];
        end
        OFS_CONTROL_D: if (pstrb[0]) begin
          ctrl_d.split_mode_bit = pwdata[0];
        end
        OFS_CTRL_E_CLR: if (pstrb[0]) begin
          ctrl_d.dir_down = ctrl_d.dir_down && !pwdata[DIR_BIT];
          ctrl_d.lock_update_bit = ctrl_q.lock_update_bit && !pwdata[LOCK_BIT];
        end
        OFS_CONTROL_E_SET: if (pstrb[0]) begin
          ctrl_d.dir_down = ctrl_d.dir_down || pwdata[DIR_BIT];
          ctrl_d.lock_update_bit = ctrl_q.lock_update_bit || pwdata[LOCK_BIT];
        end
        OFS_BUF_VALID: if (pstrb[0]) begin
          bv_d = pwdata[3:0];
        end
        OFS_EVENT_CTRL: if (pstrb[0]) begin
          ctrl_d.count_on_event_enable = pwdata[0];
        end
        OFS_COUNT: count_d = merge(count_q, pwdata, pstrb); // Write beats counting
        OFS_PERIOD: period_d = merge(period_q, pwdata, pstrb);
        OFS_PERIOD_BUF: begin
          perbuf_d = merge(perbuf_q, pwdata, pstrb);
          bv_d[0] = 1'b1; // Set wins over update clear
        end
        default: begin
        end
      endcase
      for (int i = 0; i < NCH; i++) begin
        if (paddr == OFS_COMPARE0 + 8'(4 * i)) begin
          compare_value_d[i] = merge(compare_value_q[i], pwdata, pstrb);
        end
        if (paddr == OFS_COMPBUF0 + 8'(4 * i)) begin
          compare_buffer_d[i] = merge(compare_buffer_q[i], pwdata, pstrb);
          bv_d[i+1] = 1'b1; // [R2]
        end
      end
    end
    if (cmd == CMD_RESTART) begin
      count_d = 16'h0000; // [R15]
      ctrl_d.dir_down = 1'b0; // [R15]
    end
    if (cmd == CMD_RESET && !ctrl_q.enable) begin
      ctrl_d = CTRL_RST; // [R16]
      count_d = COUNT_RST;
      period_d = PERIOD_RST;
      perbuf_d = PERIOD_RST;
      compare_value_d = {NCH{COMPARE_RST}};
      compare_buffer_d = {NCH{COMPARE_RST}};
      bv_d = BV_RST;
    end
  end

  // Flags: set wins over a write-one clear in the same cycle
  always_comb begin
    flag_set = 8'h00;
    flag_set[FLG_OVF] = ovf_evt;
    flag_set[FLG_HUNF] = hunf_evt; // [R18]
    for (int i = 0; i < NCH; i++) begin
      flag_set[FLG_CMP_LSB + i] = adv && eq[i]; // [R1] [R18]
    end
    flag_clr = (wr_acc && paddr == OFS_FLAGS && pstrb[0]) ? pwdata[7:0] : 8'h00;
    flags_d = (flags_q & ~flag_clr) | flag_set;
    if (cmd == CMD_RESET && !ctrl_q.enable) begin
      flags_d = FLAGS_RST; // [R16]
    end
  end

  // Read data is captured in the setup phase so prdata comes from flops
  always_comb begin
    prdata_d = prdata_q;
    pslverr_d = 1'b0;
    if (rd_setup) begin
      pslverr_d = !mapped(paddr);
      prdata_d = 32'h0000_0000;
      if (!pwrite) begin
        case (paddr)
          OFS_CTRL_A: prdata_d[3:0] = {ctrl_q.prescaler_select, ctrl_q.enable};
          OFS_CTRL_B: prdata_d[6:0] = {ctrl_q.channel_output_enable, 1'b0,
                                       ctrl_q.waveform_mode_select};
          OFS_CONTROL_D: prdata_d[0] = ctrl_q.split_mode_bit;
          OFS_CTRL_E_CLR,
          OFS_CONTROL_E_SET: prdata_d[1:0] = {ctrl_q.lock_update_bit, ctrl_q.dir_down};
          OFS_BUF_VALID: prdata_d[3:0] = bv_q;
          OFS_EVENT_CTRL: prdata_d[0] = ctrl_q.count_on_event_enable;
          OFS_FLAGS: prdata_d[7:0] = flags_q;
          OFS_COUNT: prdata_d[15:0] = count_q;
          OFS_PERIOD: prdata_d[15:0] = period_q;
          OFS_PERIOD_BUF: prdata_d[15:0] = perbuf_q;
          default: begin
          end
        endcase
        for (int i = 0; i < NCH; i++) begin
          if (paddr == OFS_COMPARE0 + 8'(4 * i)) begin
            prdata_d[15:0] = compare_value_q[i];
          end
          if (paddr == OFS_COMPBUF0 + 8'(4 * i)) begin
            prdata_d[15:0] = compare_buffer_q[i];
          end
        end
      end
    end
  end

  // Per-output waveform inputs; upper three exist only in split mode
  always_comb begin
    wave_ok = (ctrl_q.waveform_mode_select == WG_FREQ)
              || (ctrl_q.waveform_mode_select == WG_SINGLE)
              || (ctrl_q.waveform_mode_select == WG_DUAL);
    for (int g = 0; g < NWO; g++) begin
      if (ctrl_q.split_mode_bit) begin
        wg_mode[g] = WG_SINGLE; // [R17]
        wg_next[g] = (g < NCH) ? {8'h00, count_nat[7:0]} : {8'h00, count_nat[15:8]}; // [R24]
        wg_cmp[g] = (g < NCH) ? {8'h00, compare_value_q[g % NCH][7:0]}
                    : {8'h00, compare_value_q[g % NCH][15:8]}; // [R24]
      end else begin
        wg_mode[g] = (g < NCH) ? ctrl_q.waveform_mode_select : WG_NORMAL;
        wg_next[g] = count_nat;
        wg_cmp[g] = compare_value_q[g % NCH];
      end
      wg_match[g] = eq[g % NCH]; // [R5]
      wg_top[g] = (compare_value_q[g % NCH] == top); // [R11]
      ovr[g] = wave_ok && !ctrl_q.count_on_event_enable
               && ctrl_q.channel_output_enable[g % NCH]
               && ((g < NCH) || ctrl_q.split_mode_bit); // [R3]
      pin_d[g] = ovr[g] ? (waveform_output[g] ^ pin_invert_enable[g])
                 : port_out_value[g]; // [R4]
    end
  end

  // Generators share the tick; restart and reset clear them together
  for (genvar g = 0; g < NWO; g++) begin : g_wave
    tcw_wavegen u_wg (
      .pclk(pclk),
      .presetn(presetn),
      .waveform_mode_select(wg_mode[g]),
      .adv(adv),
      .clear(cmd == CMD_RESTART || (cmd == CMD_RESET && !ctrl_q.enable)), // [R15] [R16]
      .match(wg_match[g]),
      .next_value(wg_next[g]),
      .compare_value(wg_cmp[g]),
      .compare_at_top(wg_top[g]),
      .waveform_output(waveform_output[g])
    );
  end

  // State registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_q <= CTRL_RST;
      count_q <= COUNT_RST;
      period_q <= PERIOD_RST;
      perbuf_q <= PERIOD_RST;
      compare_value_q <= {NCH{COMPARE_RST}};
      compare_buffer_q <= {NCH{COMPARE_RST}};
      bv_q <= BV_RST;
      flags_q <= FLAGS_RST;
      prdata_q <= 32'h0000_0000;
      pslverr_q <= 1'b0;
      pin_q <= '0;
    end else begin
      ctrl_q <= ctrl_d;
      count_q <= count_d;
      period_q <= period_d;
      perbuf_q <= perbuf_d;
      compare_value_q <= compare_value_d;
      compare_buffer_q <= compare_buffer_d;
      bv_q <= bv_d;
      flags_q <= flags_d;
      prdata_q <= prdata_d;
      pslverr_q <= pslverr_d;
      pin_q <= pin_d;
    end
  end

  // Zero-wait slave: every access phase completes at once
  assign pready = 1'b1;
  assign prdata = prdata_q;
  assign pslverr = pslverr_q;
  assign pin_value = pin_q;

endmodule : tcw_top

// file: bench/tcw_checker_sva.sv
// Port checker for the timer compare and waveform unit, bound to tcw_top.
// Assumes zero-wait APB; it shadows control writes to learn the override state.
`timescale 1ns/10ps
module tcw_checker import tcw_pkg::*; (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB
  input wire logic [7:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // Pins
  input wire logic [NWO-1:0] port_out_value,
  input wire logic [NWO-1:0] pin_invert_enable,
  input wire logic [NWO-1:0] pin_value,
  input wire logic [NWO-1:0] waveform_output
);
  logic [7:0] b_q, b_d;
  logic [2:0] f_q, f_d;
  logic wr, mapped, rst_cmd;
  logic [2:0] ovr, exp_pin;

  // Shadow of mode, channel enables, event counting, split and enable
  always_comb begin
    wr = psel && penable && pwrite;
    mapped = (paddr[1:0] == 2'h0) && (paddr <= 8'h40);
    rst_cmd = wr && paddr == OFS_CONTROL_E_SET && pwdata[3:2] == 2'h3 && !f_q[0];
    b_d = (wr && paddr == OFS_CTRL_B) ? pwdata[7:0] : b_q;
    f_d = f_q;
    if (wr && paddr == OFS_CTRL_A) f_d[0] = pwdata[0];
    if (wr && paddr == OFS_EVENT_CTRL) f_d[1] = pwdata[0];
    if (wr && paddr == OFS_CONTROL_D) f_d[2] = pwdata[0];
    if (rst_cmd) begin
      b_d = 8'h00;
      f_d = 3'h0;
    end
    // Count-on-event blocks the override in every mode, split included
    ovr = b_q[6:4] & {3{b_q[2:0] != 3'h0 && !f_q[1]}};
    exp_pin = (ovr & (waveform_output[2:0] ^ pin_invert_enable[2:0])) |
              (~ovr & port_out_value[2:0]);
  end

  // Shadow registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      b_q <= 8'h00;
      f_q <= 3'h0;
    end else begin
      b_q <= b_d;
      f_q <= f_d;
    end
  end

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence s_restart;
    wr && paddr == OFS_CONTROL_E_SET && pwdata[3:2] == 2'h2;
  endsequence
  sequence s_bad_access;
    psel && penable && !mapped;
  endsequence

  a_pready_high: assert property (pready) else $error("pready low");
  a_err_unmapped: assert property (s_bad_access |-> pslverr) else $error("no slave error");
  a_err_mapped: assert property (psel && penable && mapped |-> !pslverr)
    else $error("slave error on mapped address");
  a_rd_unmapped: assert property (s_bad_access ##0 !pwrite |-> prdata == 32'h0)
    else $error("unmapped read data not zero");
  a_pin_override: assert property (1'b1 |=> pin_value[2:0] == $past(exp_pin))
    else $error("pin value not from override");
  a_event_blocks: assert property (f_q[1] |=>
    pin_value[2:0] == $past(port_out_value[2:0])) else $error("waveform with events on");
  a_restart_clear: assert property (s_restart |=> waveform_output == '0)
    else $error("outputs not cleared by restart");
  a_reset_quiet: assert property (disable iff (1'b0)
    !presetn |-> waveform_output == '0 && pin_value == '0) else $error("outputs in reset");
endmodule : tcw_checker

// file: bench/tcw_pin_model.sv
// Port pin model beside the waveform outputs: default levels, inversion, measurement.
// Assumes the bench pulses clr for one edge to open a measuring window.
`timescale 1ns/10ps
module tcw_pin_model import tcw_pkg::*; (
  // Clock
  input wire logic pclk,
  // Bench control
  input wire logic clr,
  input wire logic [NWO-1:0] inv_req,
  // Pins
  input wire logic [NWO-1:0] pin_value,
  output logic [NWO-1:0] port_out_value,
  output logic [NWO-1:0] pin_invert_enable,
  // Measurements
  output int rises [NWO],
  output int highs [NWO]
);
  logic [NWO-1:0] prev;

  // Mixed idle levels, so a missed or spurious override shows on some pin
  assign port_out_value = 6'h2a;
  assign pin_invert_enable = inv_req;

  // High cycles and rising edges per pin over one window
  always @(posedge pclk) begin
    prev <= pin_value;
    for (int i = 0; i < NWO; i++) begin
      rises[i] <= clr ? 0 : rises[i] + int'(pin_value[i] & ~prev[i]);
      highs[i] <= clr ? 0 : highs[i] + int'(pin_value[i]);
    end
  end
endmodule : tcw_pin_model

// file: bench/tb_top.sv
// Self-checking bench for the timer compare and waveform unit over APB.
// Assumes tcw_top, tcw_pin_model and the bound tcw_checker; pclk at 10 MHz.
`timescale 1ns/10ps
module tb_top import tcw_pkg::*;;
  logic pclk, psel, penable, pwrite, pready, pslverr, clr, slverr;
  logic presetn = 1'b1; // Falls by NBA at time zero so the reset edge is seen
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, q;
  logic [3:0] pstrb;
  logic [NWO-1:0] port_out_value, pin_invert_enable, pin_value, waveform_output, inv;
  int rises [NWO];
  int highs [NWO];
  int errors = 0;
  int comparisons = 0;

  tcw_top dut (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .count_event(1'b0), .port_out_value(port_out_value),
    .pin_invert_enable(pin_invert_enable), .pin_value(pin_value),
    .waveform_output(waveform_output));
  tcw_pin_model pins (.pclk(pclk), .clr(clr), .inv_req(inv), .pin_value(pin_value),
    .port_out_value(port_out_value), .pin_invert_enable(pin_invert_enable),
    .rises(rises), .highs(highs));

  task automatic stop_test();
    $display("errors=%0d comparisons=%0d", errors, comparisons);
    if (errors == 0 && comparisons > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : stop_test

  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      errors++;
      $display("[ERR] %s expected %h seen %h", name, exp, seen);
    end
  endtask : chk

  // One APB transfer; pready is sampled at rising edges, under a bound
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1) begin
      errors++;
      stop_test();
    end
    // Taken at the completing edge, before the slave's registers move on
    q = prdata;
    slverr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask : wr

  task automatic cmd(input tcw_cmd_e c);
    apb(1'b1, OFS_CONTROL_E_SET, {28'h0, c, 2'h0});
  endtask : cmd

  // Let the waveform settle, then measure the pins for n cycles
  task automatic win(input int settle, input int n);
    repeat (settle) @(posedge pclk);
    clr <= 1'b1;
    @(posedge pclk);
    clr <= 1'b0;
    repeat (n) @(posedge pclk);
    @(negedge pclk);
  endtask : win

  // Clock, 100 ns period
  initial begin
    pclk = 1'b0;
    forever #50 pclk = ~pclk;
  end

  // Main sequence
  initial begin
    presetn <= 1'b0;
    {psel, penable, pwrite, clr} = 4'h0;
    paddr = 8'h00;
    pwdata = 32'h0;
    pstrb = 4'h3;
    inv = 6'h00;
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, OFS_PERIOD, 32'h0);
    chk("period reset", q, 32'hffff);
    apb(1'b0, 8'h44, 32'h0);
    chk("unmapped", {q[31:1], slverr}, 32'h1);
    // Locked buffer only moves on the update command
    wr(OFS_CONTROL_E_SET, 32'h2);
    wr(OFS_COMPBUF0, 32'h7);
    apb(1'b0, OFS_COMPARE0, 32'h0);
    chk("compare_value_zero locked", q, 32'h0);
    cmd(CMD_UPDATE);
    apb(1'b0, OFS_COMPARE0, 32'h0);
    chk("compare_value_zero updated", q, 32'h7);
    wr(OFS_COUNT, 32'h5);
    cmd(CMD_RESTART);
    apb(1'b0, OFS_COUNT, 32'h0);
    chk("count restart", q, 32'h0);
    cmd(CMD_RESET);
    apb(1'b0, OFS_COMPARE0, 32'h0);
    chk("compare_value_zero after reset", q, 32'h0);
    // Single slope, top 9: duty 4/10, zero compare low, above top high
    wr(OFS_PERIOD, 32'h9);
    wr(OFS_COMPARE0, 32'h4);
    wr(OFS_COMPARE0 + 8'h8, 32'ha);
    wr(OFS_CTRL_B, 32'h73);
    inv <= 6'h01;
    wr(OFS_CTRL_A, 32'h1);
    win(30, 100);
    chk("ss inverted pin0", highs[0], 60);
    chk("ss zero pin1", highs[1], 0);
    chk("ss above top pin2", highs[2], 100);
    chk("idle pin3", highs[3], 100);
    apb(1'b0, OFS_FLAGS, 32'h0);
    chk("compare_value_zero flag", q[4], 1'b1);
    cmd(CMD_RESET);
    apb(1'b0, OFS_PERIOD, 32'h0);
    chk("reset refused", q, 32'h9);
    wr(OFS_EVENT_CTRL, 32'h1);
    win(4, 20);
    chk("events pin1", highs[1], 20);
    // Frequency mode: toggle every compare+1 ticks
    wr(OFS_CTRL_A, 32'h0);
    cmd(CMD_RESET);
    inv <= 6'h00;
    wr(OFS_COMPARE0, 32'h3);
    wr(OFS_CTRL_B, 32'h11);
    wr(OFS_CTRL_A, 32'h1);
    win(20, 160);
    chk("freq N1", rises[0], 20);
    wr(OFS_CTRL_A, 32'h0);
    cmd(CMD_RESTART);
    wr(OFS_CTRL_A, 32'h3);
    win(40, 160);
    chk("freq N2", rises[0], 10);
    // Dual slope, top 8: period 16, compare at top stays high
    wr(OFS_CTRL_A, 32'h0);
    cmd(CMD_RESET);
    wr(OFS_PERIOD, 32'h8);
    wr(OFS_COMPARE0, 32'h2);
    wr(OFS_COMPARE0 + 8'h8, 32'h8);
    wr(OFS_CTRL_B, 32'h75);
    wr(OFS_CTRL_A, 32'h1);
    win(40, 160);
    chk("ds period", rises[0], 10);
    chk("ds zero", highs[1], 0);
    chk("ds top", highs[2], 160);
    // Split: low top 4, high top 9, each byte its own compare
    wr(OFS_CTRL_A, 32'h0);
    cmd(CMD_RESET);
    wr(OFS_CONTROL_D, 32'h1);
    wr(OFS_PERIOD, 32'h0904);
    wr(OFS_COMPARE0, 32'h0502);
    wr(OFS_CTRL_B, 32'h13);
    wr(OFS_CTRL_A, 32'h1);
    win(40, 100);
    chk("split low", rises[0], 20);
    chk("split high", rises[3], 10);
    apb(1'b0, OFS_FLAGS, 32'h0);
    chk("high underflow", q[1], 1'b1);
    stop_test();
  end
endmodule : tb_top

bind tcw_top tcw_checker u_chk (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
  .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .port_out_value(port_out_value), .pin_invert_enable(pin_invert_enable),
  .pin_value(pin_value), .waveform_output(waveform_output));
